// File: core/pdbm_top.sv
// Purpose: pi/4 DQPSK burst modulator core with bit clock and envelope
// Assumes: Inputs from the controller are asynchronous to i_clock
// Notes:   Analog trim and drivers sit outside; this core only flags them
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Dibit FIFO between bit capture and the symbol modulator
// ----------------------------------------------------------------
module pdbm_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic             i_flush,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;

    // Full compare at the count's own width; a narrower constant would wrap to zero
    assign o_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_valid = (cnt_r != '0);
    assign o_data  = mem_r[rd_r];

    // Storage only; no reset needed on data
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_r[wr_r] <= i_data;
        end
    end

    // Pointers wrap naturally since the depth is a power of two
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else if (i_flush) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= push ? wr_r + 1'b1 : wr_r;
            rd_r  <= pop ? rd_r + 1'b1 : rd_r;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module pdbm_top
    import pdbm_pkg::*;
#(
    parameter int CAL_CYCLES = 2048
) (
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    input  wire logic       i_wake,
    input  wire logic       i_burst_request,
    input  wire logic       i_serial_tx_bit,
    input  wire logic       i_mode_select_a,
    input  wire logic       i_mode_select_b,
    output logic            o_bit_strobe_out,
    output logic            o_calibrated,
    output logic            o_offset_cal_busy,
    output logic            o_analog_drive_en,
    output logic            o_burst_delayed_out,
    output logic      [9:0] o_inphase_output,
    output logic      [9:0] o_quadrature_output
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] lvl_r;
    logic              req_prev_r;

    // A level only moves once two stages agree, filtering metastable settles
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r       <= '0;
            s2_r       <= '0;
            s3_r       <= '0;
            lvl_r      <= '0;
            req_prev_r <= 1'b0;
        end else begin
            s1_r       <= {i_mode_select_b, i_mode_select_a, i_serial_tx_bit, i_burst_request, i_wake};
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            lvl_r      <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
            req_prev_r <= lvl_r[1];
        end
    end

    wire wake_lvl  = lvl_r[0];
    wire req_lvl   = lvl_r[1];
    wire data_lvl  = lvl_r[2];
    wire tone_mode = !lvl_r[3] && lvl_r[4];   // Factory codes run as normal
    wire req_rise  = req_lvl && !req_prev_r;

    // ------------------------------------------------------------
    // Sequencer: sleep, calibration, burst
    // ------------------------------------------------------------
    pdbm_state_type state_r;
    pdbm_state_type state_nxt;
    logic [31:0]    cal_cnt_r;
    logic [1:0]     wait_r;
    logic [5:0]     div_r;
    logic           bit_ph_r;
    logic           x_bit_r;
    logic [2:0]     tails_in_r;
    logic           fifo_in_ready;

    wire busy_link  = (state_r == ST_RUN) || (state_r == ST_FLUSH);
    wire stall      = (div_r == BIT_HALF) && bit_ph_r && !fifo_in_ready;
    wire capture    = busy_link && (div_r == BIT_HALF) && !stall;
    wire push       = capture && bit_ph_r;
    wire cal_done   = (cal_cnt_r == 32'(CAL_CYCLES - 1));
    wire flush_done = (tails_in_r == TAIL_WORDS) && (div_r == BIT_LAST);
    wire burst_go   = (state_r == ST_READY) && req_rise;

    // Next state; sleep overrides everything
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_SLEEP: if (wake_lvl) state_nxt = ST_CAL;
            ST_CAL:   if (cal_done) state_nxt = ST_READY;
            ST_READY: if (req_rise) state_nxt = ST_START;
            ST_START: if (wait_r == START_WAIT - 2'h1) state_nxt = ST_RUN;
            ST_RUN:   if (!req_lvl) state_nxt = ST_FLUSH;
            ST_FLUSH: if (flush_done) state_nxt = ST_READY;
            default:  state_nxt = ST_SLEEP;
        endcase
        if (!wake_lvl) begin
            state_nxt = ST_SLEEP;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r   <= ST_SLEEP;
            cal_cnt_r <= '0;
            wait_r    <= '0;
        end else begin
            state_r   <= state_nxt;
            cal_cnt_r <= (state_r == ST_CAL) ? cal_cnt_r + 32'h1 : '0;
            wait_r    <= (state_r == ST_START) ? wait_r + 2'h1 : '0;
        end
    end

    // ------------------------------------------------------------
    // Bit clock and serial capture
    // ------------------------------------------------------------
    // Divider holds at the falling edge when the FIFO is full, so the
    // controller is stalled rather than a dibit being dropped
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_r      <= '0;
            bit_ph_r   <= 1'b0;
            x_bit_r    <= 1'b0;
            tails_in_r <= '0;
        end else if (!busy_link) begin
            div_r      <= '0;
            bit_ph_r   <= 1'b0;
            tails_in_r <= '0;
        end else begin
            div_r <= stall ? div_r : div_r + 6'h1;
            if (capture) begin
                bit_ph_r <= !bit_ph_r;
                x_bit_r  <= bit_ph_r ? x_bit_r : data_lvl;
            end
            if (push && (state_r == ST_FLUSH)) begin
                tails_in_r <= tails_in_r + 3'h1;
            end
        end
    end

    assign o_bit_strobe_out  = busy_link && (div_r < BIT_HALF);
    assign o_calibrated      = (state_r == ST_READY);
    assign o_offset_cal_busy = (state_r == ST_CAL);
    assign o_analog_drive_en = (state_r != ST_SLEEP);

    // ------------------------------------------------------------
    // Dibit buffer
    // ------------------------------------------------------------
    pdbm_word_type in_word;
    pdbm_word_type out_word;
    logic          fifo_out_valid;
    logic          pop;

    assign in_word = '{tail: (state_r == ST_FLUSH), dibit: {x_bit_r, data_lvl}};

    pdbm_fifo #(
        .WIDTH ($bits(pdbm_word_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_flush (burst_go),
        .i_valid (push),
        .o_ready (fifo_in_ready),
        .i_data  (in_word),
        .o_valid (fifo_out_valid),
        .i_ready (pop),
        .o_data  (out_word)
    );

    // ------------------------------------------------------------
    // Symbol modulator
    // ------------------------------------------------------------
    logic         mod_on_r;
    logic [6:0]   sym_div_r;
    logic [1:0]   lead_r;
    logic [2:0]   phase_r;
    logic [2:0]   tails_out_r;
    logic [4:0]   env_r;
    logic         env_up_r;
    logic [3:0]   step_r;
    logic         bdo_r;
    pdbm_imp_type imps_r [0:TAPS-1];
    pdbm_iq_type  out_r;

    wire       sym_tick  = mod_on_r && (sym_div_r == '0);
    wire       in_lead   = (lead_r != LEAD_SYMS);
    assign     pop       = sym_tick && !in_lead && fifo_out_valid;
    wire [1:0] dibit     = pop ? out_word.dibit : 2'h0;
    wire [2:0] inc       = (dibit == 2'h0) ? INC_00 :
                           (dibit == 2'h1) ? INC_01 :
                           (dibit == 2'h2) ? INC_10 : INC_11;
    wire [2:0] phase_nxt = phase_r + inc;
    wire       down_go   = pop && out_word.tail && (tails_out_r == TAIL_DOWN_AT);
    wire       mod_end   = !env_up_r && (env_r == '0) && (tails_out_r == TAIL_WORDS);

    // Cosine and sine of a phase in pi/4 units
    function automatic pdbm_imp_type lut(input logic [2:0] ph);
        pdbm_imp_type r;
        r = '{i: 8'sh00, q: 8'sh00};
        unique case (ph)
            3'h0: r = '{i: IMP_ONE,   q: 8'sh00};
            3'h1: r = '{i: IMP_DIAG,  q: IMP_DIAG};
            3'h2: r = '{i: 8'sh00,    q: IMP_ONE};
            3'h3: r = '{i: -IMP_DIAG, q: IMP_DIAG};
            3'h4: r = '{i: -IMP_ONE,  q: 8'sh00};
            3'h5: r = '{i: -IMP_DIAG, q: -IMP_DIAG};
            3'h6: r = '{i: 8'sh00,    q: -IMP_ONE};
            3'h7: r = '{i: IMP_DIAG,  q: -IMP_DIAG};
        endcase
        return r;
    endfunction

    wire pdbm_imp_type imp_nxt = tone_mode ? pdbm_imp_type'{i: 8'sh00, q: IMP_ONE} : lut(phase_nxt);

    // Restarting at the request edge forces a known phase and clean filter
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            mod_on_r    <= 1'b0;
            sym_div_r   <= '0;
            lead_r      <= '0;
            phase_r     <= '0;
            tails_out_r <= '0;
            env_up_r    <= 1'b0;
            bdo_r       <= 1'b0;
            for (int k = 0; k < TAPS; k++) imps_r[k] <= '0;
        end else if (burst_go || !wake_lvl) begin
            mod_on_r    <= burst_go;
            sym_div_r   <= '0;
            lead_r      <= '0;
            phase_r     <= '0;
            tails_out_r <= '0;
            env_up_r    <= burst_go;
            bdo_r       <= 1'b0;
            for (int k = 0; k < TAPS; k++) imps_r[k] <= '0;
        end else if (mod_on_r) begin
            sym_div_r <= (sym_div_r == SYM_LAST) ? '0 : sym_div_r + 7'h1;
            bdo_r     <= !mod_end;
            if (sym_tick) begin
                lead_r    <= in_lead ? lead_r + 2'h1 : lead_r;
                phase_r   <= phase_nxt;
                imps_r[0] <= imp_nxt;
                for (int k = 1; k < TAPS; k++) imps_r[k] <= imps_r[k-1];
                tails_out_r <= (pop && out_word.tail) ? tails_out_r + 3'h1 : tails_out_r;
                mod_on_r    <= !mod_end;
            end
            if (down_go) begin
                env_up_r <= 1'b0;
            end
        end
    end

    // Envelope steps once every 16 cycles, up or down, never overshooting
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            env_r  <= '0;
            step_r <= '0;
        end else if (!mod_on_r || burst_go) begin
            env_r  <= '0;
            step_r <= '0;
        end else begin
            step_r <= step_r + 4'h1;
            if (step_r == ENV_STEP) begin
                if (env_up_r && env_r != ENV_MAX) env_r <= env_r + 5'h1;
                else if (!env_up_r && env_r != '0) env_r <= env_r - 5'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // RRC filter: 9 symbol taps, four output phases per symbol
    // ------------------------------------------------------------
    logic signed [19:0] acc_i;
    logic signed [19:0] acc_q;
    logic signed [9:0]  sat_i;
    logic signed [9:0]  sat_q;

    always_comb begin
        int d;
        d     = 0;
        acc_i = '0;
        acc_q = '0;
        for (int k = 0; k < TAPS; k++) begin
            d = ((TAPS / 2) - k) * OSR - int'(sym_div_r[6:5]);
            d = (d < 0) ? -d : d;
            if (d < $size(RRC_COEF)) begin
                // Widen both factors first so the 8x8 product keeps all 16 bits
                acc_i = acc_i + 20'(16'($signed(imps_r[k].i)) * 16'(RRC_COEF[d]));
                acc_q = acc_q + 20'(16'($signed(imps_r[k].q)) * 16'(RRC_COEF[d]));
            end
        end
    end

    // Saturate rather than wrap; a wrap would flip the waveform polarity
    function automatic logic signed [9:0] clip(input logic signed [19:0] a);
        logic signed [19:0] s;
        s = a >>> OUT_SHIFT;
        if (s > 20'(OUT_MAX)) return OUT_MAX;
        if (s < 20'(OUT_MIN)) return OUT_MIN;
        return s[9:0];
    endfunction

    assign sat_i = clip(acc_i);
    assign sat_q = clip(acc_q);

    wire signed [15:0] env_i = (16'(sat_i) * $signed({11'h0, env_r})) >>> ENV_SHIFT;
    wire signed [15:0] env_q = (16'(sat_q) * $signed({11'h0, env_r})) >>> ENV_SHIFT;
    wire               samp  = mod_on_r && (sym_div_r[4:0] == SAMPLE_AT);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            out_r <= '0;
        end else if (!mod_on_r) begin
            out_r <= '0;
        end else if (samp) begin
            out_r <= '{i: env_i[9:0], q: env_q[9:0]};
        end
    end

    assign o_inphase_output    = out_r.i;
    assign o_quadrature_output = out_r.q;
    assign o_burst_delayed_out = bdo_r;
endmodule

// File: core/pdbm_pkg.sv
// Purpose: Shared constants and types for the pi/4 DQPSK burst modulator
// Assumes: One master clock; the bit clock is divided down from it
// Notes:   Impulse and coefficient scales are chosen for a 10-bit output
// How it works
// - Serial bits pair into dibits, X first
// - Dibit selects one of four phase steps
// - New phase is old phase plus step
// - Odd steps alternate the two four-point sets
// - RRC alpha 0.5, span eight symbols, 10-bit
// - Wake input sampled on rising clock edges
// - Wake high: calibrate, then raise calibrated flag
// - Flag drops next edge, bit clock two later
// - Controller shifts on rise; device captures falling
// - Burst start: two zero dibits during ramp-up
// - First data symbol is first captured dibit
// - Dibit in progress at fall ends ramp-down
// - Eight more bit clocks capture four dibits
// - Ramp-down reaches zero after two symbols
// - After last bit clock, flag returns high
// - Wake low: sleep, release analog outputs
// - Both mode selects low: normal modulation
// - Tone test: I zero, Q full, ramped
// - Burst indicator follows request through pipeline
// - Bit clock runs at the bit rate
package pdbm_pkg;
    localparam logic [5:0]  BIT_HALF     = 6'h20;  // Bit clock falls here
    localparam logic [5:0]  BIT_LAST     = 6'h3F;  // Master clock over 64
    localparam logic [6:0]  SYM_LAST     = 7'h7F;  // 128 cycles a symbol
    localparam logic [4:0]  SAMPLE_AT    = 5'h01;  // Sample slot in a quarter symbol
    localparam logic [1:0]  START_WAIT   = 2'h2;
    localparam logic [1:0]  LEAD_SYMS    = 2'h2;
    localparam logic [2:0]  TAIL_WORDS   = 3'h5;   // Last ramp-down dibit plus four flush dibits
    localparam logic [2:0]  TAIL_DOWN_AT = 3'h1;
    localparam logic [4:0]  ENV_MAX      = 5'h10;
    localparam int          ENV_SHIFT    = 4;
    localparam logic [3:0]  ENV_STEP     = 4'hF;   // 16 steps of 16 cycles = two symbols
    localparam logic [2:0]  INC_00       = 3'h1;   // Phase in units of pi/4
    localparam logic [2:0]  INC_01       = 3'h3;
    localparam logic [2:0]  INC_10       = 3'h7;
    localparam logic [2:0]  INC_11       = 3'h5;
    localparam logic signed [7:0] IMP_ONE  = 8'sh40;
    localparam logic signed [7:0] IMP_DIAG = 8'sh2D;
    localparam int          TAPS         = 9;
    localparam int          OSR          = 4;
    localparam int          OUT_SHIFT    = 5;
    localparam logic signed [9:0] OUT_MAX = 10'sh1FF;
    localparam logic signed [9:0] OUT_MIN = -10'sh1FF;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          SYNC_W       = 5;
    // RRC alpha 0.5 at quarter-symbol steps, centre tap first, scaled to 127
    localparam logic signed [7:0] RRC_COEF [0:16] = '{
        8'sh7F, 8'sh6D, 8'sh41, 8'sh12, -8'sh0C, -8'sh12, -8'sh08, 8'sh02, 8'sh05,
        8'sh02, -8'sh02, -8'sh02, 8'sh00, 8'sh02, 8'sh01, 8'sh00, -8'sh01};
    typedef struct packed {
        logic       tail;
        logic [1:0] dibit;
    } pdbm_word_type;
    typedef struct packed {
        logic signed [7:0] i;
        logic signed [7:0] q;
    } pdbm_imp_type;
    typedef struct packed {
        logic signed [9:0] i;
        logic signed [9:0] q;
    } pdbm_iq_type;
    typedef enum logic [5:0] {
        ST_SLEEP = 6'h01,
        ST_CAL   = 6'h02,
        ST_READY = 6'h04,
        ST_START = 6'h08,
        ST_RUN   = 6'h10,
        ST_FLUSH = 6'h20
    } pdbm_state_type;
endpackage

// File: testbench/pdbm_chk.sv
// Purpose: Port assertions for the burst modulator
// Assumes: Stimulus holds each level for several cycles
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module pdbm_chk #(
    parameter int CAL_CYCLES = 2048
) (
    input wire logic       i_clock,
    input wire logic       i_nrst,
    input wire logic       i_wake,
    input wire logic       i_burst_request,
    input wire logic       i_serial_tx_bit,
    input wire logic       i_mode_select_a,
    input wire logic       i_mode_select_b,
    input wire logic       o_bit_strobe_out,
    input wire logic       o_calibrated,
    input wire logic       o_offset_cal_busy,
    input wire logic       o_analog_drive_en,
    input wire logic       o_burst_delayed_out,
    input wire logic [9:0] o_inphase_output,
    input wire logic [9:0] o_quadrature_output
);
    int busy_cnt_r;
    int hi_cnt_r;
    int rise_cnt_r;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    // Run lengths; too long for a repetition operator
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_cnt_r <= 0;
            hi_cnt_r   <= 0;
            rise_cnt_r <= 0;
        end else begin
            busy_cnt_r <= o_offset_cal_busy ? busy_cnt_r + 1 : 0;
            hi_cnt_r   <= o_bit_strobe_out ? hi_cnt_r + 1 : 0;
            rise_cnt_r <= o_calibrated ? 0 : rise_cnt_r + int'(o_bit_strobe_out && hi_cnt_r == 0);
        end
    end
    chk_wake_cal: assert property ($rose(i_wake) && !o_analog_drive_en |-> ##[2:6] o_offset_cal_busy)
        else $error("calibration did not start after wake");
    chk_cal_length: assert property ($fell(o_offset_cal_busy) && i_wake |-> o_calibrated && busy_cnt_r == CAL_CYCLES)
        else $error("calibration length or flag wrong");
    chk_sleep_off: assert property ($fell(i_wake) |-> ##[1:6] (!o_analog_drive_en && !o_calibrated))
        else $error("sleep did not release outputs");
    chk_req_drop: assert property (o_calibrated && $rose(i_burst_request) |-> ##[1:6] !o_calibrated)
        else $error("ready flag held after request");
    chk_strobe_lag: assert property ($fell(o_calibrated) && i_wake && i_burst_request |-> !o_bit_strobe_out [*2] ##1 o_bit_strobe_out)
        else $error("bit clock start not two cycles after flag drop");
    chk_strobe_high: assert property ($fell(o_bit_strobe_out) |-> hi_cnt_r == 32)
        else $error("bit clock high phase not 32 cycles");
    chk_burst_end: assert property ($rose(o_calibrated) && !$past(o_offset_cal_busy) |-> rise_cnt_r >= 10 && rise_cnt_r % 2 == 0)
        else $error("burst ended with a wrong bit count");
    chk_idle_quiet: assert property (o_calibrated |-> !o_bit_strobe_out)
        else $error("bit clock runs while ready");
    chk_ind_rise: assert property ($fell(o_calibrated) && i_wake && i_burst_request |-> ##[1:2] o_burst_delayed_out)
        else $error("burst indicator late");
    chk_tone_i: assert property (!i_mode_select_a && i_mode_select_b && $past(i_mode_select_b, 8) |-> o_inphase_output == 10'h000)
        else $error("tone mode inphase not zero");
endmodule

// File: testbench/pdbm_ctrl_model.sv
// Purpose: Controller that feeds serial bits to the modulator
// Assumes: Bit clock sampled by the master clock
// Notes:   Line wanders between bursts so nothing relies on a held value
`timescale 1ns/1ps
// ----------------------------------------
// Controller model
// ----------------------------------------
module pdbm_ctrl_model (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_strobe,
    input  wire logic [63:0] i_pattern,
    output logic             o_bit,
    output logic [7:0]       o_sent
);
    logic       strobe_q_r;
    logic [6:0] idle_r;
    // New bit just after the strobe rises; device takes it on the fall
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            strobe_q_r <= 1'b0;
            idle_r     <= 7'h00;
            o_sent     <= 8'h00;
            o_bit      <= 1'b0;
        end else begin
            strobe_q_r <= i_strobe;
            if (i_strobe && !strobe_q_r) begin
                o_bit  <= i_pattern[o_sent[5:0]];
                o_sent <= o_sent + 8'h01;
                idle_r <= 7'h00;
            end else if (idle_r != 7'h7F) begin
                idle_r <= idle_r + 7'h01;
            end else begin
                o_bit <= ~o_bit;
            end
        end
    end
endmodule

// File: testbench/pdbm_top_tb.sv
// Purpose: Self-checking bench for the burst modulator
// Assumes: Short calibration through CAL_CYCLES
// Notes:   Waveform detail is judged by the checker and peak checks
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module pdbm_top_tb;
    logic        clock   = 1'b0;
    logic        nrst    = 1'b0;
    logic        wake    = 1'b0;
    logic        req     = 1'b0;
    logic        mode_a  = 1'b0;  // Factory codes are never selected
    logic        mode_b  = 1'b0;
    logic [63:0] pattern = 64'h0;
    logic        ser;
    logic        strobe;
    logic        cal;
    logic        busy;
    logic        drv;
    logic        bdo;
    logic [9:0]  iout;
    logic [9:0]  qout;
    logic [7:0]  sent;
    logic [7:0]  base;
    logic [7:0]  tgt;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          peak_q;
    logic        inph_seen;
    int          k;
    initial forever #4 clock = ~clock;  // Master clock driven from outside
    pdbm_top #(.CAL_CYCLES(16)) i_pdbm_top (
        .i_clock(clock), .i_nrst(nrst), .i_wake(wake), .i_burst_request(req),
        .i_serial_tx_bit(ser), .i_mode_select_a(mode_a), .i_mode_select_b(mode_b),
        .o_bit_strobe_out(strobe), .o_calibrated(cal), .o_offset_cal_busy(busy),
        .o_analog_drive_en(drv), .o_burst_delayed_out(bdo),
        .o_inphase_output(iout), .o_quadrature_output(qout));
    pdbm_ctrl_model i_pdbm_ctrl_model (
        .i_clock(clock), .i_nrst(nrst), .i_strobe(strobe), .i_pattern(pattern),
        .o_bit(ser), .o_sent(sent));
    // Track what a burst put on the outputs
    always @(posedge clock) begin
        if ($signed(qout) > peak_q) peak_q <= $signed(qout);
        if (iout != 10'h000) inph_seen <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic pick(input int sel);
        if (sel == 0) return cal;
        if (sel == 1) return bdo;
        return 8'(sent - base) == tgt;
    endfunction
    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic wait_for(input int sel, input logic lvl);
        int n;
        n = 0;
        while (pick(sel) !== lvl && n < 4000) begin
            @(posedge clock);
            n++;
        end
        if (n == 4000) begin
            miscompares++;
            test_done();
        end
    endtask
    // One burst: request drops 10 cycles into bit nbits
    task automatic run_burst(input int nbits, input logic tone);
        @(posedge clock);
        mode_b    <= tone;
        pattern   <= {$urandom, $urandom};
        peak_q    = 0;
        inph_seen = 1'b0;
        base      = sent;
        tgt       = 8'(nbits);
        repeat (12) @(posedge clock);
        req <= 1'b1;  // Only ever raised while the ready flag is high
        wait_for(2, 1'b1);
        repeat (10) @(posedge clock);
        req <= 1'b0;
        wait_for(0, 1'b1);
        check(8'(sent - base), 8'(((nbits + 1) / 2) * 2 + 8));
        wait_for(1, 1'b0);
        repeat (40) @(posedge clock);
        check(iout, 10'h000);
        check(qout, 10'h000);
        if (tone) check(peak_q > 0, 1'b1);
        else check(inph_seen, 1'b1);
        $display("test burst of %0d bits done", nbits);
    endtask
    initial begin
        void'($urandom(28));
        repeat (5) @(posedge clock);
        check({strobe, cal, busy, drv, bdo}, 5'h00);
        nrst <= 1'b1;
        @(posedge clock);
        wake <= 1'b1;
        wait_for(0, 1'b1);
        check(busy, 1'b0);
        $display("test wake done");
        // Shortest bursts first, then random lengths and modes
        run_burst(1, 1'b0);
        run_burst(2, 1'b0);
        run_burst(5, 1'b1);
        for (k = 0; k < 4; k++) begin
            run_burst($urandom_range(12, 3), 1'($urandom_range(1, 0)));
        end
        @(posedge clock);
        wake <= 1'b0;
        repeat (10) @(posedge clock);
        check(drv, 1'b0);
        check(cal, 1'b0);
        wake <= 1'b1;
        wait_for(0, 1'b1);
        run_burst(4, 1'b0);
        $display("test sleep and wake done");
        test_done();
    end
endmodule
bind pdbm_top pdbm_chk #(.CAL_CYCLES(CAL_CYCLES)) i_pdbm_chk (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_wake(i_wake), .i_burst_request(i_burst_request),
    .i_serial_tx_bit(i_serial_tx_bit), .i_mode_select_a(i_mode_select_a),
    .i_mode_select_b(i_mode_select_b), .o_bit_strobe_out(o_bit_strobe_out),
    .o_calibrated(o_calibrated), .o_offset_cal_busy(o_offset_cal_busy),
    .o_analog_drive_en(o_analog_drive_en), .o_burst_delayed_out(o_burst_delayed_out),
    .o_inphase_output(o_inphase_output), .o_quadrature_output(o_quadrature_output));
